// *** src/bwm_monitor.sv ***
// Purpose: breaker wear monitor with curve table, per-phase counters and alarms
// Assumes: inputs synchronous to pclk, APB slave answering in one access cycle
// Notes: interpolation runs in the log domain, so counts are approximate
`default_nettype none
module bwm_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire bwm_pkg::bwm_phase_t phase_current,
	input wire logic supervised_trip_output,
	input wire logic [31:0] time_stamp,
	output logic first_alarm,
	output logic second_alarm,
	output bwm_pkg::bwm_event_t alarm_event,
	output logic busy
);
	import bwm_pkg::*;

	logic trip_d_ff;
	logic trip_pend_ff;
	logic clr_pend_ff;
	logic mode_clr_ff;
	bwm_state_t st_ff;
	logic [2:0] job_ff;
	logic [3:0] step_ff;
	bwm_log_t rem_ff;
	bwm_log_t den_ff;
	bwm_log_t lck_ff;
	bwm_log_t lck1_ff;
	logic [FRAC_W-1:0] t_ff;
	bwm_log_t logc_ff [NJOB];
	bwm_phase_t broken_ff;
	bwm_phase_t work_ff;
	logic [31:0] trip_time_ff;
	bwm_cur_t pt_cur_ff [NPTS];
	bwm_cnt_t pt_cnt_ff [NPTS];
	bwm_cnt_t ctr_ff [NAL][NPH];
	bwm_cur_t al_cur_ff [NAL];
	bwm_cnt_t al_lim_ff [NAL];
	logic [3:0] ev_en_ff;
	logic [NAL-1:0] alarm_ff;
	bwm_event_t event_ff;
	logic busy_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;

	function automatic logic bwm_in(input logic [7:0] a, input logic [7:0] base,
		input logic [3:0] n);
		return (a >= base) && (a < base + {2'b00, n, 2'b00}) && (a[1:0] == 2'b00);
	endfunction : bwm_in

	function automatic bwm_cnt_t bwm_min3(input bwm_cnt_t x, input bwm_cnt_t y,
		input bwm_cnt_t z);
		bwm_cnt_t m;
		m = (x < y) ? x : y;
		return (z < m) ? z : m;
	endfunction : bwm_min3

	// APB decode; every window sits on a 32-byte boundary so bits 4:2 index it
	wire setup = psel & ~penable;
	wire wr = psel & penable & pready_ff & pwrite;
	wire [2:0] widx = paddr[4:2];
	wire in_cnt1 = bwm_in(paddr, A_CNT1, N_PH_WORDS);
	wire in_cnt2 = bwm_in(paddr, A_CNT2, N_PH_WORDS);
	wire in_brk = bwm_in(paddr, A_BROKEN, N_PH_WORDS);
	wire in_pc = bwm_in(paddr, A_PT_CUR, N_PT_WORDS);
	wire in_pn = bwm_in(paddr, A_PT_CNT, N_PT_WORDS);
	wire w_ctrl = wr && (paddr == A_CTRL);
	wire clr_cmd = w_ctrl && pwdata[CTRL_CLEAR];
	wire [1:0] pidx = widx[1:0];

	logic [31:0] rd_data;
	logic rd_ok;
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = 1'b1;
		if (paddr == A_CTRL) begin
			rd_data = 32'({ev_en_ff, 1'b0});
		end else if (paddr == A_AL1_CUR) begin
			rd_data = 32'(al_cur_ff[0]);
		end else if (paddr == A_AL1_LIM) begin
			rd_data = 32'(al_lim_ff[0]);
		end else if (paddr == A_AL2_CUR) begin
			rd_data = 32'(al_cur_ff[1]);
		end else if (paddr == A_AL2_LIM) begin
			rd_data = 32'(al_lim_ff[1]);
		end else if (paddr == A_STATUS) begin
			rd_data = 32'({alarm_ff, busy_ff});
		end else if (paddr == A_TRIP_TIME) begin
			rd_data = trip_time_ff;
		end else if (in_brk) begin
			rd_data = 32'(broken_ff.ph[pidx]);
		end else if (in_cnt1) begin
			rd_data = 32'(ctr_ff[0][pidx]);
		end else if (in_cnt2) begin
			rd_data = 32'(ctr_ff[1][pidx]);
		end else if (in_pc) begin
			rd_data = 32'(pt_cur_ff[widx]);
		end else if (in_pn) begin
			rd_data = 32'(pt_cnt_ff[widx]);
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Answer one cycle after setup; data is taken in setup so it stands through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~rd_ok;
			prdata_ff <= (setup & ~pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	// Alarm settings and event enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_en_ff <= 4'h0;
			al_cur_ff <= '{RST_AL_CUR, RST_AL_CUR};
			al_lim_ff <= '{RST_AL_LIM, RST_AL_LIM};
		end else begin
			if (w_ctrl) begin
				ev_en_ff <= pwdata[CTRL_EV +: 4];
			end
			if (wr && paddr == A_AL1_CUR) begin
				al_cur_ff[0] <= pwdata[CUR_W-1:0];
			end
			if (wr && paddr == A_AL1_LIM) begin
				al_lim_ff[0] <= pwdata[CNT_W-1:0];
			end
			if (wr && paddr == A_AL2_CUR) begin
				al_cur_ff[1] <= pwdata[CUR_W-1:0];
			end
			if (wr && paddr == A_AL2_LIM) begin
				al_lim_ff[1] <= pwdata[CNT_W-1:0];
			end
		end
	end

	// Curve table; reset fills every point as unused
	for (genvar k = 0; k < NPTS; k++) begin : g_pt
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				pt_cur_ff[k] <= UNUSED_POINT_CURRENT;
				pt_cnt_ff[k] <= UNUSED_POINT_COUNT;
			end else begin
				if (wr && in_pc && widx == 3'(k)) begin
					pt_cur_ff[k] <= pwdata[CUR_W-1:0];
				end
				if (wr && in_pn && widx == 3'(k)) begin
					pt_cnt_ff[k] <= pwdata[CNT_W-1:0];
				end
			end
		end
	end

	// Trip edge and clear are queued so neither is lost while a run is busy
	wire idle = (st_ff == ST_IDLE);
	wire trip_edge = supervised_trip_output & ~trip_d_ff;
	wire start_trip = idle & trip_pend_ff;
	wire start_clr = idle & ~trip_pend_ff & clr_pend_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_d_ff <= 1'b0;
			trip_pend_ff <= 1'b0;
			clr_pend_ff <= 1'b0;
			mode_clr_ff <= 1'b0;
			broken_ff <= '0;
			work_ff <= '0;
			trip_time_ff <= 32'h0000_0000;
		end else begin
			trip_d_ff <= supervised_trip_output;
			trip_pend_ff <= trip_edge | (trip_pend_ff & ~start_trip);
			clr_pend_ff <= clr_cmd | (clr_pend_ff & ~start_clr);
			if (trip_edge) begin
				broken_ff <= phase_current;
				trip_time_ff <= time_stamp;
			end
			if (start_trip | start_clr) begin
				work_ff <= broken_ff;
				mode_clr_ff <= start_clr;
			end
		end
	end

	// Segment search over points two to eight; unused points never bracket
	bwm_cur_t job_cur;
	logic [2:0] lo;
	assign job_cur = (job_ff < 3'(JOB_PH0)) ? al_cur_ff[job_ff[0]] :
		work_ff.ph[2'(job_ff - 3'(JOB_PH0))];
	always_comb begin
		lo = PT_FIRST;
		for (int k = 1; k < NPTS; k++) begin
			if (pt_cnt_ff[k] != UNUSED_POINT_COUNT && job_cur >= pt_cur_ff[k]) begin
				lo = 3'(k);
			end
		end
	end
	wire [2:0] hi = lo + 3'h1;
	wire bwm_log_t lg_i = bwm_lg2(CNT_W'(job_cur));
	wire bwm_log_t lg_lo = bwm_lg2(CNT_W'(pt_cur_ff[lo]));
	wire bwm_log_t lg_hi = bwm_lg2(CNT_W'(pt_cur_ff[hi]));
	// Outside a bracket the nearest used point's count is taken as is
	wire seg_ok = (lo != PT_LAST) && (pt_cnt_ff[hi] != UNUSED_POINT_COUNT) &&
		(job_cur >= pt_cur_ff[lo]) && (lg_hi > lg_lo);
	wire bwm_log_t num = (lg_i >= lg_hi) ? (lg_hi - lg_lo - 13'h0001) : (lg_i - lg_lo);

	// log C = log Ck + (log Ck+1 - log Ck) * t; same as a / I^n on the segment
	wire [LOG_W:0] rem2 = {rem_ff, 1'b0};
	wire sub_ok = rem2 >= {1'b0, den_ff};
	wire signed [LOG_W:0] dlc = $signed({1'b0, lck1_ff}) - $signed({1'b0, lck_ff});
	wire signed [LOG_W+FRAC_W+1:0] prod = dlc * $signed({1'b0, t_ff});
	wire signed [LOG_W+1:0] lc_sum = $signed({2'b00, lck_ff}) +
		(LOG_W+2)'(prod >>> FRAC_W);
	wire bwm_log_t lc_new = lc_sum[LOG_W-1:0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_IDLE;
			job_ff <= 3'h0;
			step_ff <= 4'h0;
			rem_ff <= '0;
			den_ff <= '0;
			lck_ff <= '0;
			lck1_ff <= '0;
			t_ff <= '0;
			logc_ff <= '{default: '0};
		end else begin
			case (st_ff)
				ST_IDLE: begin
					if (start_trip | start_clr) begin
						job_ff <= 3'h0;
						st_ff <= ST_SEEK;
					end
				end
				ST_SEEK: begin
					lck_ff <= bwm_lg2(pt_cnt_ff[lo]);
					lck1_ff <= bwm_lg2(pt_cnt_ff[hi]);
					rem_ff <= num;
					den_ff <= lg_hi - lg_lo;
					t_ff <= '0;
					step_ff <= 4'h0;
					st_ff <= seg_ok ? ST_DIV : ST_STORE;
				end
				ST_DIV: begin
					rem_ff <= sub_ok ? LOG_W'(rem2 - {1'b0, den_ff}) : rem2[LOG_W-1:0];
					t_ff <= {t_ff[FRAC_W-2:0], sub_ok};
					step_ff <= step_ff + 4'h1;
					if (step_ff == DIV_LAST) begin
						st_ff <= ST_STORE;
					end
				end
				ST_STORE: begin
					logc_ff[job_ff] <= lc_new;
					job_ff <= job_ff + 3'h1;
					st_ff <= (job_ff == JOB_LAST) ? ST_APPLY : ST_SEEK;
				end
				ST_APPLY: begin
					st_ff <= ST_IDLE;
				end
				default: begin
					st_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Counters; a trip weighs each phase current against both alarm levels
	for (genvar a = 0; a < NAL; a++) begin : g_al
		for (genvar p = 0; p < NPH; p++) begin : g_ph
			wire signed [LOG_W:0] dd = $signed({1'b0, logc_ff[a]}) -
				$signed({1'b0, logc_ff[JOB_PH0+p]});
			wire bwm_cnt_t dec = (work_ff.ph[p] < al_cur_ff[a]) ? ONE_DEC :
				bwm_ex2(dd[LOG_W] ? '0 : dd[LOG_W-1:0]);
			wire bwm_cnt_t nxt_ctr = mode_clr_ff ? bwm_ex2(logc_ff[a]) :
				((ctr_ff[a][p] > dec) ? (ctr_ff[a][p] - dec) : '0);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctr_ff[a][p] <= '0;
				end else if (st_ff == ST_APPLY) begin
					ctr_ff[a][p] <= nxt_ctr;
				end
			end
		end
	end

	wire [NAL-1:0] nxt_alarm;
	for (genvar a = 0; a < NAL; a++) begin : g_cmp
		assign nxt_alarm[a] = bwm_min3(ctr_ff[a][0], ctr_ff[a][1], ctr_ff[a][2]) <
			al_lim_ff[a];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_ff <= '0;
			event_ff <= '0;
			busy_ff <= 1'b0;
		end else begin
			alarm_ff <= nxt_alarm;
			event_ff.al1_on <= nxt_alarm[0] & ~alarm_ff[0] & ev_en_ff[0];
			event_ff.al1_off <= ~nxt_alarm[0] & alarm_ff[0] & ev_en_ff[1];
			event_ff.al2_on <= nxt_alarm[1] & ~alarm_ff[1] & ev_en_ff[2];
			event_ff.al2_off <= ~nxt_alarm[1] & alarm_ff[1] & ev_en_ff[3];
			busy_ff <= ~idle | start_trip | start_clr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign first_alarm = alarm_ff[0];
	assign second_alarm = alarm_ff[1];
	assign alarm_event = event_ff;
	assign busy = busy_ff;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	capture_currents_a: assert property ($rose(supervised_trip_output) |=>
		broken_ff == $past(phase_current)) else $error("trip currents not captured");
	trip_stamp_a: assert property ($rose(supervised_trip_output) |=>
		trip_time_ff == $past(time_stamp)) else $error("trip time not captured");
	held_trip_a: assert property ((idle && !trip_pend_ff && !clr_pend_ff &&
		!trip_edge && !clr_cmd) |=> (idle && !trip_pend_ff)) else $error("run without edge");
	below_one_a: assert property ((st_ff == ST_APPLY && !mode_clr_ff &&
		work_ff.ph[0] < al_cur_ff[0] && ctr_ff[0][0] != '0) |=>
		ctr_ff[0][0] == $past(ctr_ff[0][0]) - ONE_DEC) else $error("low current step not one");
	no_wrap_a: assert property ((st_ff == ST_APPLY && !mode_clr_ff) |=>
		ctr_ff[1][2] <= $past(ctr_ff[1][2])) else $error("counter wrapped or rose");
	alarm_min_a: assert property ((ctr_ff[0][1] < al_lim_ff[0]) |=>
		first_alarm) else $error("alarm missed on low phase");
	event_gate_a: assert property ($rose(first_alarm) |->
		alarm_event.al1_on == $past(ev_en_ff[0])) else $error("event gating wrong");
	clear_done_a: assert property ($rose(clr_pend_ff) |->
		##[1:130] (st_ff == ST_APPLY && mode_clr_ff)) else $error("clear not applied");

	trip_run_c: cover property (st_ff == ST_APPLY && !mode_clr_ff);
	clear_run_c: cover property (st_ff == ST_APPLY && mode_clr_ff);
	alarm_rise_c: cover property ($rose(second_alarm));
endmodule : bwm_monitor
`default_nettype wire

// *** src/bwm_pkg.sv ***
// Purpose: constants, types and helpers for the breaker wear monitor
// Assumes: one clock, registers over APB, currents and counts unsigned
// Notes: logarithms are base two in fixed point, five integer and eight fraction bits
// What this block does
// - Wear evaluated separately for each phase
// - Capture currents when supervised trip activates
// - Curve table holds eight current/count points
// - Unused points hold big current, count one
// - Interpolate logarithmically between points two to eight
// - Count equals a over current to n
// - Two alarms with current level and limit
// - Alarm when operations left below limit
// - Each trip decrements both alarms' counters
// - Alarm signals drive the output matrix
// - Alarm change events only when enabled
// - Clear reloads counters with maximum at level
// - Three counters per alarm, smallest compared
// - Decrement is alarm count over trip count
// - Current below alarm level decrements by one
// - Record latest trip time and currents
`default_nettype none
package bwm_pkg;
	localparam int CUR_W = 16;
	localparam int CNT_W = 17;
	localparam int LOG_W = 13;
	localparam int FRAC_W = 8;
	localparam int NPTS = 8;
	localparam int NPH = 3;
	localparam int NAL = 2;
	localparam int NJOB = 5;
	localparam int JOB_PH0 = 2;
	localparam int CTRL_CLEAR = 0;
	localparam int CTRL_EV = 1;
	localparam logic [3:0] DIV_LAST = 4'h7;
	localparam logic [2:0] JOB_LAST = 3'h4;
	localparam logic [2:0] PT_FIRST = 3'h1;
	localparam logic [2:0] PT_LAST = 3'h7;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_AL1_CUR = 8'h04;
	localparam logic [7:0] A_AL1_LIM = 8'h08;
	localparam logic [7:0] A_AL2_CUR = 8'h0C;
	localparam logic [7:0] A_AL2_LIM = 8'h10;
	localparam logic [7:0] A_STATUS = 8'h14;
	localparam logic [7:0] A_TRIP_TIME = 8'h18;
	localparam logic [7:0] A_CNT1 = 8'h40;
	localparam logic [7:0] A_BROKEN = 8'h60;
	localparam logic [7:0] A_PT_CUR = 8'h80;
	localparam logic [7:0] A_PT_CNT = 8'hA0;
	localparam logic [7:0] A_CNT2 = 8'hC0;
	localparam logic [3:0] N_PH_WORDS = 4'h3;
	localparam logic [3:0] N_PT_WORDS = 4'h8;
	localparam logic [CUR_W-1:0] UNUSED_POINT_CURRENT = 16'hFFFF;
	localparam logic [CNT_W-1:0] UNUSED_POINT_COUNT = 17'h0_0001;
	localparam logic [CUR_W-1:0] RST_AL_CUR = 16'h0000;
	localparam logic [CNT_W-1:0] RST_AL_LIM = 17'h0_0001;
	localparam logic [CNT_W-1:0] ONE_DEC = 17'h0_0001;
	localparam logic [CNT_W-1:0] CNT_MAX = 17'h1_FFFF;

	typedef logic [CUR_W-1:0] bwm_cur_t;
	typedef logic [CNT_W-1:0] bwm_cnt_t;
	typedef logic [LOG_W-1:0] bwm_log_t;
	typedef struct packed {
		bwm_cur_t [NPH-1:0] ph;
	} bwm_phase_t;
	typedef struct packed {
		logic al2_off;
		logic al2_on;
		logic al1_off;
		logic al1_on;
	} bwm_event_t;
	typedef enum {ST_IDLE, ST_SEEK, ST_DIV, ST_STORE, ST_APPLY} bwm_state_t;

	// Leading one gives the integer part, the bits below it a linear mantissa
	function automatic bwm_log_t bwm_lg2(input bwm_cnt_t v);
		logic [4:0] p;
		bwm_cnt_t norm;
		p = 5'h00;
		for (int i = 0; i < CNT_W; i++) begin
			if (v[i]) begin
				p = 5'(i);
			end
		end
		norm = v << (5'(CNT_W - 1) - p);
		return {p, norm[CNT_W-2 -: FRAC_W]};
	endfunction : bwm_lg2

	// Inverse of the above, rounded to the nearest whole count and saturated
	function automatic bwm_cnt_t bwm_ex2(input bwm_log_t x);
		logic [40:0] m;
		m = 41'({1'b1, x[FRAC_W-1:0]}) << x[LOG_W-1:FRAC_W];
		m = m + 41'(1 << (FRAC_W - 1));
		m = m >> FRAC_W;
		return (m > 41'(CNT_MAX)) ? CNT_MAX : m[CNT_W-1:0];
	endfunction : bwm_ex2
endpackage : bwm_pkg
`default_nettype wire

// *** tb/breaker_wear_monitor_tb.sv ***
// Purpose: self-checking bench for the breaker wear monitor
// Assumes: APB waits for pready however late it comes, runs finish within a few hundred cycles
// Notes: the monitor interpolates in coarse log steps, so curve counts get a tolerance
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module breaker_wear_monitor_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import bwm_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic first_alarm, second_alarm, busy, supervised_trip_output;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, time_stamp, trip_stamp, rd;
	logic [3:0] ev_bits;
	bwm_phase_t phase_current;
	bwm_event_t alarm_event;
	int n_fail, total_checks, cycles, seed, lim2;
	int ev_cnt [4];
	int c1b [3];
	int c2b [3];
	bwm_cur_t rc;
	bwm_monitor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phase_current(phase_current),
		.supervised_trip_output(supervised_trip_output), .time_stamp(time_stamp),
		.first_alarm(first_alarm), .second_alarm(second_alarm), .alarm_event(alarm_event),
		.busy(busy));
	bwm_relay_model i_relay (.pclk(pclk), .phase_current(phase_current),
		.supervised_trip_output(supervised_trip_output), .time_stamp(time_stamp),
		.trip_stamp(trip_stamp));
	assign ev_bits = alarm_event;
	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			if (ev_bits[i] === 1'b1) begin
				ev_cnt[i]++;
			end
		end
		cycles++;
		if (cycles == 12000) begin
			n_fail++;
			report_and_stop();
		end
	end
	// Permitted count between two curve points, a over I to the n
	function automatic real perm(real i, real ik, real ck, real ik1, real ck1);
		real n;
		n = $ln(ck / ck1) / $ln(ik1 / ik);
		return ck * (ik / i) ** n;
	endfunction : perm
	// Log steps in the monitor are coarse, hence a few percent of slack
	function automatic logic near(int got, real exp);
		return (real'(got) >= exp * 0.95 - 1.0) && (real'(got) <= exp * 1.05 + 1.0);
	endfunction : near
	// Only the bench timeout ends a wait, so a dead slave shows up as a mismatch
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge pclk);
		while (busy !== 1'b0 && n < 400) begin
			@(posedge pclk);
			n++;
		end
		`CHK(busy, 1'b0)
	endtask : wait_idle
	task automatic read_counters();
		for (int p = 0; p < 3; p++) begin
			apb(1'b0, A_CNT1 + 8'(4 * p), 32'h0000_0000);
			c1b[p] = int'(rd);
			apb(1'b0, A_CNT2 + 8'(4 * p), 32'h0000_0000);
			c2b[p] = int'(rd);
		end
	endtask : read_counters
	task automatic set_curve(input int c2, input int i3, input int c3);
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, A_PT_CUR + 8'(4 * k),
				(k == 0) ? 0 : (k == 1) ? 1250 : (k == 2) ? i3 : 32'h0000_FFFF);
			apb(1'b1, A_PT_CNT + 8'(4 * k), (k < 2) ? c2 : (k == 2) ? c3 : 1);
		end
	endtask : set_curve
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		seed = 72102;
		{n_fail, total_checks, cycles} = '0;
		ev_cnt = '{0, 0, 0, 0};
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK(first_alarm, 1'b1)
		apb(1'b0, A_AL1_LIM, 32'h0000_0000);
		`CHK(rd, 32'h0000_0001)
		apb(1'b0, A_PT_CUR + 8'h1C, 32'h0000_0000);
		`CHK(rd, 32'h0000_FFFF)
		apb(1'b0, 8'h3C, 32'h0000_0000);
		`CHK(err, 1'b1)
		set_curve(10000, 31000, 80);
		apb(1'b1, A_AL1_CUR, 1250);
		apb(1'b1, A_AL1_LIM, 50);
		apb(1'b1, A_AL2_CUR, 6000);
		apb(1'b1, A_AL2_LIM, 50);
		apb(1'b1, A_CTRL, 32'h0000_0001);
		wait_idle();
		read_counters();
		for (int p = 0; p < 3; p++) begin
			`CHK(near(c2b[p], perm(6000, 1250, 10000, 31000, 80)), 1'b1)
			`CHK(near(c1b[p], 10000.0), 1'b1)
		end
		`CHK({second_alarm, first_alarm}, 2'b00)
		`CHK(ev_cnt[1] + ev_cnt[3], 0)
		// Unequal poles, trip held well past the run
		i_relay.trip(12500, 12500, 1500, 90);
		wait_idle();
		for (int p = 0; p < 3; p++) begin
			apb(1'b0, A_CNT2 + 8'(4 * p), 32'h0000_0000);
			`CHK(c2b[p] - int'(rd), (p < 2) ? 3 : 1)
			apb(1'b0, A_CNT1 + 8'(4 * p), 32'h0000_0000);
			`CHK(near(c1b[p] - int'(rd), (p < 2) ? 10000 / perm(12500, 1250, 10000, 31000, 80)
				: 1.0), 1'b1)
			apb(1'b0, A_BROKEN + 8'(4 * p), 32'h0000_0000);
			`CHK(rd, (p < 2) ? 32'd12500 : 32'd1500)
		end
		apb(1'b0, A_TRIP_TIME, 32'h0000_0000);
		`CHK(rd, trip_stamp)
		read_counters();
		// Limit sits one below the smallest phase counter
		lim2 = c2b[2] - 3;
		apb(1'b1, A_AL2_LIM, lim2);
		for (int t = 0; t < 3; t++) begin
			read_counters();
			rc = 16'($unsigned($random(seed)) % 1250);
			i_relay.trip(rc, 16'($unsigned($random(seed)) % 1250), 16'(rc / 2), 4);
			wait_idle();
			for (int p = 0; p < 3; p++) begin
				apb(1'b0, A_CNT1 + 8'(4 * p), 32'h0000_0000);
				`CHK(rd, 32'(c1b[p] - 1))
				apb(1'b0, A_CNT2 + 8'(4 * p), 32'h0000_0000);
				`CHK(rd, 32'(c2b[p] - 1))
			end
		end
		`CHK({second_alarm, first_alarm}, 2'b10)
		`CHK(ev_cnt[2], 0)
		// Steep curve so two trips use up alarm one
		set_curve(100, 2500, 2);
		apb(1'b1, A_CTRL, 32'h0000_001F);
		wait_idle();
		read_counters();
		`CHK(near(c1b[0], 100.0), 1'b1)
		`CHK(first_alarm, 1'b0)
		for (int t = 0; t < 3; t++) begin
			i_relay.trip(2500, 2500, 2500, 4);
			wait_idle();
		end
		for (int p = 0; p < 3; p++) begin
			apb(1'b0, A_CNT1 + 8'(4 * p), 32'h0000_0000);
			`CHK(rd, 32'h0000_0000)
			apb(1'b0, A_CNT2 + 8'(4 * p), 32'h0000_0000);
			`CHK(rd, 32'h0000_0000)
		end
		`CHK(first_alarm, 1'b1)
		`CHK(ev_cnt[0], 1)
		// Clear again so alarm one falls with its off event enabled
		apb(1'b1, A_CTRL, 32'h0000_001F);
		wait_idle();
		apb(1'b0, A_STATUS, 32'h0000_0000);
		`CHK(rd, 32'h0000_0004)
		`CHK(first_alarm, 1'b0)
		`CHK(ev_cnt[1], 1)
		`CHK(ev_cnt[2] + ev_cnt[3], 0)
		report_and_stop();
	end
endmodule : breaker_wear_monitor_tb
`default_nettype wire

// *** tb/bwm_relay_model.sv ***
// Purpose: stand-in for the relay measurement path and breaker failure supervision
// Assumes: currents settle one cycle before the supervised trip output rises
// Notes: the stamp clock runs free, so each trip gets its own stamp
`default_nettype none
module bwm_relay_model (
	input wire logic pclk,
	output bwm_pkg::bwm_phase_t phase_current,
	output logic supervised_trip_output,
	output logic [31:0] time_stamp,
	output logic [31:0] trip_stamp
);
	timeunit 1ns;
	timeprecision 100ps;
	import bwm_pkg::*;
	logic trip_q;
	initial begin
		phase_current = '0;
		supervised_trip_output = 1'b0;
		time_stamp = 32'h0000_0000;
		trip_stamp = 32'h0000_0000;
		trip_q = 1'b0;
	end
	// Stamp seen by the monitor at the first edge where the trip shows high
	always @(posedge pclk) begin
		time_stamp <= time_stamp + 32'h0000_0001;
		trip_q <= supervised_trip_output;
		if (supervised_trip_output && !trip_q) begin
			trip_stamp <= time_stamp;
		end
	end
	// A held trip is normal for a breaker that clears slowly, so hold may be long
	task automatic trip(input bwm_cur_t c0, input bwm_cur_t c1, input bwm_cur_t c2,
		input int hold);
		@(posedge pclk);
		phase_current <= {c2, c1, c0};
		@(posedge pclk);
		supervised_trip_output <= 1'b1;
		repeat (hold) @(posedge pclk);
		supervised_trip_output <= 1'b0;
	endtask : trip
endmodule : bwm_relay_model
`default_nettype wire
